// ### mcmr_pkg.sv
package mcmr_pkg;
	// ==========================================
	// register map
	localparam logic [5:0]  MCMR_ADDR_OPCFG      = 6'h09;
	localparam logic [15:0] MCMR_OPCFG_RESET     = 16'h000c;
	localparam logic [15:0] MCMR_OPCFG_WMASK     = 16'hffff;
	// ==========================================
	// command byte fields
	localparam int          MCMR_CMD_DIR_BIT     = 7;
	localparam int          MCMR_CMD_RSV_BIT     = 6;
	localparam int          MCMR_CMD_ADDR_W      = 6;
	// ==========================================
	// operating_config field positions
	localparam int          MCMR_B_HPF_BYP       = 0;
	localparam int          MCMR_B_LPF_BYP       = 1;
	localparam int          MCMR_B_PULSE_DIS     = 2;
	localparam int          MCMR_B_SAG_DIS       = 3;
	localparam int          MCMR_B_SUSPEND       = 4;
	localparam int          MCMR_B_TEMP          = 5;
	localparam int          MCMR_B_SOFT_RESET_BIT         = 6;
	localparam int          MCMR_B_LINE_CYCLE_ACCUM_MODE       = 7;
	localparam int          MCMR_B_ISHORT        = 8;
	localparam int          MCMR_B_VSHORT        = 9;
	localparam int          MCMR_B_SWAP          = 10;
	localparam int          MCMR_B_RATE_LO       = 11;
	localparam int          MCMR_B_SRC_LO        = 13;
	localparam int          MCMR_B_POS_ONLY      = 15;
	// ==========================================
	// timing
	localparam int          MCMR_CLK_MHZ         = 200;
	localparam int          MCMR_SOFT_RESET_BIT_US        = 18;
	localparam int          MCMR_SOFT_RESET_BIT_CYC       = MCMR_SOFT_RESET_BIT_US * MCMR_CLK_MHZ;
	localparam int          MCMR_SOFT_RESET_BIT_HOLD_CYC  = 16;
	localparam logic [1:0]  MCMR_SRC_RESERVED    = 2'h1;
endpackage : mcmr_pkg

// ### mcmr_if.sv
`timescale 1ns/1ps
interface mcmr_if;
	logic        cmd_valid;
	logic [7:0]  cmd_byte;
	logic        data_valid;
	logic [15:0] wdata;
	logic        rdata_valid;
	logic [15:0] rdata;
	modport device (input cmd_valid, cmd_byte, data_valid, wdata, output rdata_valid, rdata);
	modport host   (output cmd_valid, cmd_byte, data_valid, wdata, input rdata_valid, rdata);
endinterface : mcmr_if

// ### mcmr_device.sv
// Behaviour
// [RULE1] each transfer begins with a command byte
// [RULE2] low six bits select the register
// [RULE3] host keeps command bit six zero
// [RULE4] bit seven one writes, zero reads
// [RULE5] bit 0 bypasses current highpass filter
// [RULE6] bit 1 bypasses power lowpass filter
// [RULE7] bits 2,3 disable pulse, sag; reset one
// [RULE8] bit 4 suspends both converters
// [RULE9] bit 5 starts temperature, self clears
// [RULE10] bit 6 soft reset, 18 us blackout
// [RULE11] bit 7 selects line cycle accumulation
// [RULE12] bits 8,9 short current, voltage inputs
// [RULE13] bit 10 swaps channel input pairs
// [RULE14] bits 12:11 waveform rate clk/128..1024
// [RULE15] bits 14:13 waveform source, 01 reserved
// [RULE16] bit 15 positive only accumulation
`timescale 1ns/1ps
module mcmr_device
	import mcmr_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	mcmr_if.device           bus,
	input  wire logic        temp_done_i,
	output logic             temp_start_o,
	output logic             soft_reset_o,
	output logic             current_highpass_bypass_o,
	output logic             power_lowpass_bypass_o,
	output logic             pulse_output_disable_o,
	output logic             sag_detect_disable_o,
	output logic             converter_suspend_o,
	output logic             line_cycle_accum_mode_o,
	output logic             current_input_short_o,
	output logic             voltage_input_short_o,
	output logic             channel_swap_o,
	output logic [10:0]      waveform_divisor_o,
	output logic [1:0]       waveform_source_select_o,
	output logic             positive_only_accumulation_o
);
	typedef enum logic [1:0] {
		MCMR_ST_CMD  = 2'b01,
		MCMR_ST_DATA = 2'b10
	} mcmr_state_t;

	typedef struct packed {
		mcmr_state_t state;
		logic        dir_wr;
		logic [5:0]  addr;
		logic [15:0] opcfg;
		logic        rvalid;
		logic [15:0] rdata;
		logic        temp_busy;
		logic [4:0]  rst_cnt;
	} mcmr_dev_t;

	typedef struct packed {
		logic       positive_only_accumulation;
		logic [1:0] waveform_source_select;
		logic [1:0] waveform_rate_select;
		logic       channel_swap;
		logic       voltage_input_short;
		logic       current_input_short;
		logic       line_cycle_accum_mode;
		logic       soft_reset_bit;
		logic       temp_conversion_start;
		logic       converter_suspend;
		logic       sag_detect_disable;
		logic       pulse_output_disable;
		logic       power_lowpass_bypass;
		logic       current_highpass_bypass;
	} mcmr_mode_t;

	mcmr_dev_t  r;
	mcmr_dev_t  next_r;
	mcmr_mode_t mode;
	logic       cmd_take;
	logic       data_take;
	logic       opcfg_write;
	logic       opcfg_read;
	logic       temp_set;
	logic       temp_clear;
	logic       srst_active;
	logic       srst_done;

	// ==========================================
	// decode helpers
	function automatic logic mcmr_is_write(input logic [7:0] cmd);
		mcmr_is_write = cmd[MCMR_CMD_DIR_BIT];
	endfunction : mcmr_is_write

	function automatic logic [5:0] mcmr_cmd_addr(input logic [7:0] cmd);
		mcmr_cmd_addr = cmd[MCMR_CMD_ADDR_W-1:0];
	endfunction : mcmr_cmd_addr

	function automatic logic mcmr_hits_opcfg(input logic [5:0] addr);
		mcmr_hits_opcfg = (addr == MCMR_ADDR_OPCFG);
	endfunction : mcmr_hits_opcfg

	function automatic logic [15:0] mcmr_read_mux(input logic [5:0] addr, input logic [15:0] opcfg);
		// unmapped addresses read as zero
		mcmr_read_mux = mcmr_hits_opcfg(addr) ? opcfg : 16'h0000;
	endfunction : mcmr_read_mux

	function automatic logic [10:0] mcmr_rate_div(input logic [1:0] code);
		mcmr_rate_div = 11'h080 << code; // RULE14
	endfunction : mcmr_rate_div

	function automatic mcmr_mode_t mcmr_mode_view(input logic [15:0] v);
		mcmr_mode_view.positive_only_accumulation = v[MCMR_B_POS_ONLY];
		mcmr_mode_view.waveform_source_select     = v[MCMR_B_SRC_LO+:2];
		mcmr_mode_view.waveform_rate_select       = v[MCMR_B_RATE_LO+:2];
		mcmr_mode_view.channel_swap               = v[MCMR_B_SWAP];
		mcmr_mode_view.voltage_input_short        = v[MCMR_B_VSHORT];
		mcmr_mode_view.current_input_short        = v[MCMR_B_ISHORT];
		mcmr_mode_view.line_cycle_accum_mode      = v[MCMR_B_LINE_CYCLE_ACCUM_MODE];
		mcmr_mode_view.soft_reset_bit             = v[MCMR_B_SOFT_RESET_BIT];
		mcmr_mode_view.temp_conversion_start      = v[MCMR_B_TEMP];
		mcmr_mode_view.converter_suspend          = v[MCMR_B_SUSPEND];
		mcmr_mode_view.sag_detect_disable         = v[MCMR_B_SAG_DIS];
		mcmr_mode_view.pulse_output_disable       = v[MCMR_B_PULSE_DIS];
		mcmr_mode_view.power_lowpass_bypass       = v[MCMR_B_LPF_BYP];
		mcmr_mode_view.current_highpass_bypass    = v[MCMR_B_HPF_BYP];
	endfunction : mcmr_mode_view

	// ==========================================
	// transfer events
	assign cmd_take    = (r.state == MCMR_ST_CMD) && bus.cmd_valid; // RULE1
	assign data_take   = (r.state == MCMR_ST_DATA) && bus.data_valid;
	assign opcfg_write = data_take && r.dir_wr && mcmr_hits_opcfg(r.addr); // RULE4
	assign opcfg_read  = data_take && !r.dir_wr; // RULE4

	// ==========================================
	// temperature conversion
	assign temp_set    = opcfg_write && bus.wdata[MCMR_B_TEMP]; // RULE9
	// a start written in the finishing cycle wins over the self clear
	assign temp_clear  = r.temp_busy && temp_done_i && !temp_set; // RULE9

	// ==========================================
	// soft reset
	assign srst_active = r.opcfg[MCMR_B_SOFT_RESET_BIT]; // RULE10
	assign srst_done   = srst_active && (r.rst_cnt == 5'(MCMR_SOFT_RESET_BIT_HOLD_CYC - 1)); // RULE10

	// ==========================================
	// command and data sequencing
	always_comb begin
		next_r        = r;
		next_r.rvalid = 1'b0;
		unique case (r.state)
			MCMR_ST_CMD: begin
				if (cmd_take) begin
					next_r.dir_wr = mcmr_is_write(bus.cmd_byte); // RULE4
					next_r.addr   = mcmr_cmd_addr(bus.cmd_byte); // RULE2
					next_r.state  = MCMR_ST_DATA; // RULE1
				end
			end
			MCMR_ST_DATA: begin
				if (data_take) begin
					next_r.state = MCMR_ST_CMD;
				end
			end
			default: next_r.state = MCMR_ST_CMD;
		endcase
		if (opcfg_write) begin
			next_r.opcfg = bus.wdata & MCMR_OPCFG_WMASK;
		end
		if (opcfg_read) begin
			next_r.rvalid = 1'b1; // RULE4
			next_r.rdata  = mcmr_read_mux(r.addr, r.opcfg); // RULE2
		end
		// temperature start self clears when conversion completes
		if (temp_set) begin
			next_r.temp_busy = 1'b1; // RULE9
		end else if (temp_clear) begin
			next_r.temp_busy          = 1'b0;
			next_r.opcfg[MCMR_B_TEMP] = 1'b0; // RULE9
		end
		// soft reset returns every field to default after a short pulse
		if (srst_done) begin
			next_r.opcfg     = MCMR_OPCFG_RESET; // RULE10
			next_r.rst_cnt   = 5'h00;
			next_r.temp_busy = 1'b0;
			next_r.state     = MCMR_ST_CMD;
		end else if (srst_active) begin
			next_r.rst_cnt = r.rst_cnt + 5'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			r.state     <= MCMR_ST_CMD;
			r.dir_wr    <= 1'b0;
			r.addr      <= 6'h00;
			r.opcfg     <= MCMR_OPCFG_RESET; // RULE7
			r.rvalid    <= 1'b0;
			r.rdata     <= 16'h0000;
			r.temp_busy <= 1'b0;
			r.rst_cnt   <= 5'h00;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================
	// outputs
	assign mode                           = mcmr_mode_view(r.opcfg);
	assign bus.rdata_valid                = r.rvalid;
	assign bus.rdata                      = r.rdata;
	assign temp_start_o                   = mode.temp_conversion_start & r.temp_busy; // RULE9
	assign soft_reset_o                   = mode.soft_reset_bit; // RULE10
	assign current_highpass_bypass_o      = mode.current_highpass_bypass; // RULE5
	assign power_lowpass_bypass_o         = mode.power_lowpass_bypass; // RULE6
	assign pulse_output_disable_o         = mode.pulse_output_disable; // RULE7
	assign sag_detect_disable_o           = mode.sag_detect_disable; // RULE7
	assign converter_suspend_o            = mode.converter_suspend; // RULE8
	assign line_cycle_accum_mode_o        = mode.line_cycle_accum_mode; // RULE11
	assign current_input_short_o          = mode.current_input_short; // RULE12
	assign voltage_input_short_o          = mode.voltage_input_short; // RULE12
	assign channel_swap_o                 = mode.channel_swap; // RULE13
	assign waveform_divisor_o             = mcmr_rate_div(mode.waveform_rate_select); // RULE14
	assign waveform_source_select_o       = mode.waveform_source_select; // RULE15
	assign positive_only_accumulation_o   = mode.positive_only_accumulation; // RULE16
endmodule : mcmr_device

// ### mcmr_host.sv
`timescale 1ns/1ps
module mcmr_host
	import mcmr_pkg::*;
#(
	parameter int SOFT_RESET_BIT_CYC = MCMR_SOFT_RESET_BIT_CYC
)(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	mcmr_if.host             bus,
	input  wire logic [5:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic             ready_o,
	output logic [15:0]      rdata_o,
	output logic             rdata_valid_o
);
	typedef enum logic [2:0] {
		MCMR_H_IDLE = 3'b001,
		MCMR_H_DATA = 3'b010,
		MCMR_H_WAIT = 3'b100
	} mcmr_hstate_t;

	typedef struct packed {
		mcmr_hstate_t state;
		logic         cmd_valid;
		logic [7:0]   cmd_byte;
		logic         data_valid;
		logic [15:0]  wdata;
		logic         is_wr;
		logic [15:0]  rdata;
		logic         rvalid;
		logic [31:0]  wait_cnt;
	} mcmr_host_t;

	mcmr_host_t r;
	mcmr_host_t next_r;

	// ==========================================
	// sequencing: command byte, data, optional blackout
	always_comb begin
		next_r            = r;
		next_r.cmd_valid  = 1'b0;
		next_r.data_valid = 1'b0;
		next_r.rvalid     = 1'b0;
		if (bus.rdata_valid) begin
			next_r.rdata  = bus.rdata;
			next_r.rvalid = 1'b1;
		end
		unique case (r.state)
			MCMR_H_IDLE: begin
				if (wr_i || rd_i) begin
					next_r.cmd_valid = 1'b1; // RULE1
					next_r.cmd_byte  = {wr_i, 1'b0, addr_i}; // RULE3
					next_r.is_wr     = wr_i; // RULE4
					next_r.wdata     = wdata_i;
					next_r.state     = MCMR_H_DATA;
				end
			end
			MCMR_H_DATA: begin
				next_r.data_valid = 1'b1;
				next_r.state      = MCMR_H_IDLE;
				if (r.is_wr && r.cmd_byte[5:0] == MCMR_ADDR_OPCFG && r.wdata[MCMR_B_SOFT_RESET_BIT]) begin
					next_r.wait_cnt = 32'(SOFT_RESET_BIT_CYC); // RULE10
					next_r.state    = MCMR_H_WAIT;
				end
			end
			MCMR_H_WAIT: begin
				next_r.wait_cnt = r.wait_cnt - 32'h1;
				if (r.wait_cnt <= 32'h1) begin
					next_r.state = MCMR_H_IDLE; // RULE10
				end
			end
			default: next_r.state = MCMR_H_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			r.state      <= MCMR_H_IDLE;
			r.cmd_valid  <= 1'b0;
			r.cmd_byte   <= 8'h00;
			r.data_valid <= 1'b0;
			r.wdata      <= 16'h0000;
			r.is_wr      <= 1'b0;
			r.rdata      <= 16'h0000;
			r.rvalid     <= 1'b0;
			r.wait_cnt   <= 32'h0;
		end else begin
			r <= next_r;
		end
	end

	assign bus.cmd_valid  = r.cmd_valid;
	assign bus.cmd_byte   = r.cmd_byte;
	assign bus.data_valid = r.data_valid;
	assign bus.wdata      = r.wdata;
	assign ready_o        = (r.state == MCMR_H_IDLE);
	assign rdata_o        = r.rdata;
	assign rdata_valid_o  = r.rvalid;
endmodule : mcmr_host

// ### mcmr_props.sv
`timescale 1ns/1ps
module mcmr_props
	import mcmr_pkg::*;
#(
	parameter int SOFT_RESET_BIT_CYC = MCMR_SOFT_RESET_BIT_CYC
)(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        data_valid,
	input  wire logic [15:0] wdata,
	input  wire logic        rdata_valid,
	input  wire logic [15:0] rdata
);
	// ==========================================
	// open transfer, expected mode and blackout
	logic        await_d;
	logic [7:0]  cmd_q;
	logic [15:0] shadow;
	int          blk;
	wire         hit = cmd_q[5:0] == MCMR_ADDR_OPCFG;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			await_d <= 1'b0;
			cmd_q   <= 8'h00;
			shadow  <= MCMR_OPCFG_RESET;
			blk     <= 0;
		end else begin
			blk <= (blk > 0) ? blk - 1 : 0;
			if (cmd_valid && !await_d) begin
				await_d <= 1'b1;
				cmd_q   <= cmd_byte;
			end else if (data_valid && await_d) begin
				await_d <= 1'b0;
				if (cmd_q[7] && hit) begin
					shadow <= wdata[6] ? MCMR_OPCFG_RESET : wdata;
					blk    <= wdata[6] ? SOFT_RESET_BIT_CYC - 2 : 0;
				end
			end
		end
	end
	// ==========================================
	// properties
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_rd;
		data_valid && await_d && !cmd_q[7];
	endsequence
	sequence s_wr;
		data_valid && await_d && cmd_q[7];
	endsequence
	a_data_after_cmd: assert property (data_valid |-> await_d)
		else $error("data word without a command byte");
	a_cmd_rsv_zero: assert property (cmd_valid && !await_d |-> !cmd_byte[6])
		else $error("command bit six not zero");
	a_read_answers: assert property (s_rd |=> rdata_valid)
		else $error("read not answered next cycle");
	a_write_quiet: assert property (s_wr |=> !rdata_valid)
		else $error("write produced read data");
	a_answer_cause: assert property (rdata_valid |-> $past(data_valid) && !$past(cmd_q[7]))
		else $error("read data without a read");
	a_unmapped_zero: assert property (s_rd ##0 !hit |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_mode_readback: assert property (s_rd ##0 hit |=> ((rdata ^ shadow) & 16'hffdf) == 16'h0000)
		else $error("mode read back differs");
	a_reset_blackout: assert property (blk != 0 |-> !cmd_valid)
		else $error("access during soft reset blackout");
endmodule : mcmr_props

// ### tb.sv
`timescale 1ns/1ps
module tb;
	import mcmr_pkg::*;
	localparam int SW = MCMR_SOFT_RESET_BIT_CYC;
	logic        mclk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        temp_done_i = 1'b0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [5:0]  addr_i = 6'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic [15:0] got;
	logic [15:0] m;
	logic        ready_o, rdata_valid_o, temp_start_o, soft_reset_o;
	logic [15:0] rdata_o;
	wire  [22:0] pins;
	int          n_fail = 0;
	int          checks_done = 0;
	mcmr_if bus ();
	mcmr_device i_mcmr_device (.mclk_i, .rstn_i, .bus(bus), .temp_done_i, .temp_start_o, .soft_reset_o,
		.current_highpass_bypass_o(pins[0]), .power_lowpass_bypass_o(pins[1]), .pulse_output_disable_o(pins[2]),
		.sag_detect_disable_o(pins[3]), .converter_suspend_o(pins[4]), .line_cycle_accum_mode_o(pins[5]),
		.current_input_short_o(pins[6]), .voltage_input_short_o(pins[7]), .channel_swap_o(pins[8]),
		.waveform_divisor_o(pins[19:9]), .waveform_source_select_o(pins[21:20]), .positive_only_accumulation_o(pins[22]));
	mcmr_host #(.SOFT_RESET_BIT_CYC(SW)) i_mcmr_host (.mclk_i, .rstn_i, .bus(bus), .addr_i, .wdata_i, .wr_i, .rd_i,
		.ready_o, .rdata_o, .rdata_valid_o);
	mcmr_props #(.SOFT_RESET_BIT_CYC(SW)) i_mcmr_props (.mclk_i, .rstn_i, .cmd_valid(bus.cmd_valid), .cmd_byte(bus.cmd_byte),
		.data_valid(bus.data_valid), .wdata(bus.wdata), .rdata_valid(bus.rdata_valid), .rdata(bus.rdata));
	function automatic logic [10:0] exp_div(input logic [1:0] code);
		case (code)
			2'h0: return 11'h080;
			2'h1: return 11'h100;
			2'h2: return 11'h200;
			default: return 11'h400;
		endcase
	endfunction : exp_div
	function automatic logic [22:0] exp_pins(input logic [15:0] v);
		return {v[15], v[14:13], exp_div(v[12:11]), v[10:7], v[4:0]};
	endfunction : exp_pins
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic op(input logic w, input logic [5:0] a, input logic [15:0] d);
		int n;
		n = 0;
		do @(posedge mclk_i); while (ready_o !== 1'b1 && ++n < SW + 100);
		if (ready_o !== 1'b1) chk("ready", ready_o, 1'b1);
		wr_i    <= w;
		rd_i    <= !w;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		n = 0;
		if (!w) begin
			do @(posedge mclk_i); while (rdata_valid_o !== 1'b1 && ++n < 10);
			if (rdata_valid_o !== 1'b1) chk("rvalid", rdata_valid_o, 1'b1);
			got = rdata_o;
		end
	endtask : op
	task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
		op(1'b0, a, 16'h0000);
		chk("rdata", got, e);
	endtask : rdchk
	task automatic wrap_up();
		$display("fails %0d checks %0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// ==========================================
	// clock, watchdog and sequence
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (10000) @(posedge mclk_i);
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(79));
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		rdchk(MCMR_ADDR_OPCFG, 16'h000c);
		chk("pins", pins, exp_pins(16'h000c));
		for (int i = 0; i < 16; i++) begin
			m = (16'($urandom) & 16'h879f) | 16'(i << 11);
			op(1'b1, MCMR_ADDR_OPCFG, m);
			rdchk(MCMR_ADDR_OPCFG, m);
			chk("pins", pins, exp_pins(m));
		end
		op(1'b1, 6'h0a, 16'hffff);
		rdchk(6'h0a, 16'h0000);
		rdchk(MCMR_ADDR_OPCFG, m);
		op(1'b1, MCMR_ADDR_OPCFG, 16'h0020);
		rdchk(MCMR_ADDR_OPCFG, 16'h0020);
		chk("temp", temp_start_o, 1);
		op(1'b1, MCMR_ADDR_OPCFG, 16'h0020);
		@(posedge mclk_i) temp_done_i <= 1'b1;
		@(posedge mclk_i) temp_done_i <= 1'b0;
		rdchk(MCMR_ADDR_OPCFG, 16'h0020);
		chk("temp", temp_start_o, 1);
		@(posedge mclk_i) temp_done_i <= 1'b1;
		@(posedge mclk_i) temp_done_i <= 1'b0;
		rdchk(MCMR_ADDR_OPCFG, 16'h0000);
		chk("temp", temp_start_o, 0);
		op(1'b1, MCMR_ADDR_OPCFG, 16'h0043);
		repeat (3) @(posedge mclk_i);
		chk("srst", soft_reset_o, 1);
		rdchk(MCMR_ADDR_OPCFG, 16'h000c);
		chk("pins", pins, exp_pins(16'h000c));
		wrap_up();
	end
endmodule : tb
